/* File: rtl/mrpu_pkg.sv */
// Constants shared by the memory host controller and its timing counter
package mrpu_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int STARTUP_TIME_US = 2000;
  localparam int STARTUP_CYC = (STARTUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYCLE_NS = 35;
  localparam int ADDR_ACCESS_NS = 35;
  localparam int ENABLE_ACCESS_NS = 35;
  localparam int OUTEN_ACCESS_NS = 15;
  localparam int ENABLE_HIZ_NS = 15;
  localparam int OUTEN_HIZ_NS = 10;
  localparam int HIGH_HOLD_NS = 2;
  localparam int ACCESS_NS = (ADDR_ACCESS_NS > ENABLE_ACCESS_NS) ? ADDR_ACCESS_NS : ENABLE_ACCESS_NS;
  localparam int ACCESS_ALL_NS = (ACCESS_NS > OUTEN_ACCESS_NS) ? ACCESS_NS : OUTEN_ACCESS_NS;
  localparam int ACCESS_CYC = (ACCESS_ALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_CYC = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIZ_NS = (ENABLE_HIZ_NS > OUTEN_HIZ_NS) ? ENABLE_HIZ_NS : OUTEN_HIZ_NS;
  localparam int RELEASE_CYC = (HIZ_NS + HIGH_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_NS = 15;
  localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  typedef enum logic [6:0] {
    MRPU_WAIT = 7'h01,
    MRPU_IDLE = 7'h02,
    MRPU_RD   = 7'h04,
    MRPU_RCAP = 7'h08,
    MRPU_WR   = 7'h10,
    MRPU_WEND = 7'h20,
    MRPU_REL  = 7'h40
  } mrpu_state_t;
endpackage

/* File: rtl/mrpu_delay.sv */
// Down counter that reports when a loaded number of cycles has passed
`timescale 1ns/100ps
module mrpu_delay #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  // Status
  output logic o_done
);
  logic [W-1:0] cnt;
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt <= '0;
    end else if (i_load) begin
      cnt <= i_count;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end
  assign o_done = (cnt == '0) && !i_load;
endmodule // mrpu_delay

/* File: rtl/mrpu_host.sv */
// Host controller for a byte-wide asynchronous non-volatile memory
// What this block does
// - Wait 2 ms after supply good before any access.
// - Hold chip-select and write strobe high through start-up.
// - Keep both strobes high from reset for longer than start-up.
// - After brownout, wait full start-up again before accessing.
// - Write strobe high in reads; each read cycle at least 35 ns.
// - Writes happen only while chip-select and write strobe overlap low.
`timescale 1ns/100ps
module mrpu_host
  import mrpu_pkg::*;
#(
  parameter int ADDR_W = 17,
  parameter int DATA_W = 8,
  parameter int STARTUP_CYCLES = STARTUP_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Supply monitor, asynchronous
  input wire logic i_supply_ok,
  // User request
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic o_ready,
  output logic o_rvalid,
  output logic [DATA_W-1:0] o_rdata,
  // Memory pins
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic o_mem_cs_n,
  output logic o_mem_we_n,
  output logic o_mem_oe_n,
  input wire logic [DATA_W-1:0] i_mem_dq,
  output logic [DATA_W-1:0] o_mem_dq,
  output logic o_mem_dq_oe
);
  mrpu_state_t state;
  mrpu_state_t next_state;
  logic [2:0] sup_sync;
  logic supply_good;
  logic dly_load;
  logic [CNT_W-1:0] dly_count;
  logic dly_done;
  logic [31:0] su_cnt;
  logic su_done;
  logic [DATA_W-1:0] dq_s1;
  logic [DATA_W-1:0] dq_s2;
  logic wr_op;

  // Supply flag passes three flops; a change counts once the last two agree
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sup_sync <= 3'h0;
    end else begin
      sup_sync <= {sup_sync[1:0], i_supply_ok};
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      supply_good <= 1'b0;
    end else if (sup_sync[2] == sup_sync[1]) begin
      supply_good <= sup_sync[2];
    end
  end

  // Start-up timer restarts on every reset and on every supply loss
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      su_cnt <= 32'h0;
      su_done <= 1'b0;
    end else if (!supply_good) begin
      su_cnt <= 32'h0;
      su_done <= 1'b0;
    end else if (su_cnt > 32'(STARTUP_CYCLES)) begin
      su_done <= 1'b1;
    end else begin
      su_cnt <= su_cnt + 32'h1;
    end
  end

  // Cycle counts are rounded up so every minimum is met at 50 ns periods
  mrpu_delay #(.W(CNT_W)) u_delay (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(dly_load),
    .i_count(dly_count),
    .o_done(dly_done)
  );

  always_comb begin
    next_state = state;
    dly_load = 1'b0;
    dly_count = '0;
    case (state)
      MRPU_WAIT: begin
        if (su_done) begin
          next_state = MRPU_IDLE;
        end
      end
      MRPU_IDLE: begin
        if (!su_done) begin
          next_state = MRPU_WAIT;
        end else if (i_req && i_we) begin
          next_state = MRPU_WR;
          dly_load = 1'b1;
          dly_count = CNT_W'(WRITE_CYC);
        end else if (i_req) begin
          next_state = MRPU_RD;
          dly_load = 1'b1;
          dly_count = CNT_W'(ACCESS_CYC > CYCLE_CYC ? ACCESS_CYC : CYCLE_CYC);
        end
      end
      MRPU_RD: begin
        if (dly_done) begin
          next_state = MRPU_RCAP;
        end
      end
      MRPU_RCAP: begin
        next_state = MRPU_REL;
        dly_load = 1'b1;
        dly_count = CNT_W'(RELEASE_CYC);
      end
      MRPU_WR: begin
        if (dly_done) begin
          next_state = MRPU_WEND;
        end
      end
      MRPU_WEND: begin
        next_state = MRPU_REL;
        dly_load = 1'b1;
        dly_count = CNT_W'(RELEASE_CYC);
      end
      MRPU_REL: begin
        if (dly_done) begin
          next_state = su_done ? MRPU_IDLE : MRPU_WAIT;
        end
      end
      default: begin
        next_state = MRPU_WAIT;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= MRPU_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // Address and write data latched at request
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_mem_addr <= '0;
      o_mem_dq <= '0;
      wr_op <= 1'b0;
    end else if (state == MRPU_IDLE && i_req && su_done) begin
      o_mem_addr <= i_addr;
      o_mem_dq <= i_wdata;
      wr_op <= i_we;
    end
  end

  // Strobes; a brownout mid-write still ends the pulse at once
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_mem_cs_n <= 1'b1;
      o_mem_we_n <= 1'b1;
      o_mem_oe_n <= 1'b1;
      o_mem_dq_oe <= 1'b0;
    end else begin
      o_mem_cs_n <= !(next_state == MRPU_RD || next_state == MRPU_RCAP || next_state == MRPU_WR);
      o_mem_we_n <= !(next_state == MRPU_WR && su_done);
      o_mem_oe_n <= !(next_state == MRPU_RD || next_state == MRPU_RCAP);
      o_mem_dq_oe <= (next_state == MRPU_WR || next_state == MRPU_WEND);
    end
  end

  // Double register on the data bus; capture waits out the access time
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
    end else begin
      dq_s1 <= i_mem_dq;
      dq_s2 <= dq_s1;
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= 1'b0;
      if (state == MRPU_RCAP) begin
        o_rdata <= dq_s2;
        o_rvalid <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ready <= 1'b0;
    end else begin
      o_ready <= (next_state == MRPU_IDLE) && su_done;
    end
  end
endmodule // mrpu_host

/* File: test/mrpu_host_monitor.sv */
// Checker watching the memory host controller pins
`timescale 1ns/100ps
module mrpu_host_monitor #(
  parameter int ADDR_W = 17,
  parameter int STARTUP_CYCLES = 40000
) (
  input wire logic i_ref_clk, i_sys_rst, i_supply_ok, i_req, i_we,
  input wire logic o_ready, o_rvalid, o_mem_cs_n, o_mem_we_n, o_mem_oe_n, o_mem_dq_oe,
  input wire logic [ADDR_W-1:0] o_mem_addr
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  int up;
  int low;
  // Supply-good cycles; the design's synchroniser only adds delay, so this is an upper bound on its count
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) up <= 0;
    else if (!i_supply_ok) up <= 0;
    else if (up < STARTUP_CYCLES) up <= up + 1;
  end
  // Supply-low cycles; a loss is seen only after the synchroniser, and an access under way may finish first
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) low <= 0;
    else if (i_supply_ok) low <= 0;
    else if (low < 8) low <= low + 1;
  end
  a_quiet_startup: assert property (up < STARTUP_CYCLES && (up > 0 || low >= 8) |-> o_mem_cs_n && o_mem_we_n)
    else $error("strobe low during start-up");
  a_ready_late: assert property (up > 0 && up < STARTUP_CYCLES |-> !o_ready)
    else $error("ready before start-up ended");
  a_ready_drop: assert property (low >= 8 |-> !o_ready)
    else $error("ready during supply loss");
  a_read_we_high: assert property (!o_mem_oe_n |-> o_mem_we_n)
    else $error("write strobe low in read");
  a_bus_free: assert property (!o_mem_oe_n |-> !o_mem_dq_oe)
    else $error("host drives bus in read");
  a_write_overlap: assert property (!o_mem_we_n |-> !o_mem_cs_n)
    else $error("write strobe without select");
  a_take_busy: assert property (o_ready && i_req |=> !o_ready)
    else $error("ready stays after take");
  a_read_answer: assert property (o_ready && i_req && !i_we |-> ##[3:5] o_rvalid)
    else $error("read answer missing");
  a_rvalid_pulse: assert property (o_rvalid |=> !o_rvalid)
    else $error("rvalid longer than one cycle");
  a_addr_held: assert property (!o_mem_cs_n && $past(!o_mem_cs_n) |-> $stable(o_mem_addr))
    else $error("address moved in cycle");
  a_high_gap: assert property ($rose(o_mem_cs_n) |=> o_mem_cs_n)
    else $error("select high too short");
endmodule // mrpu_host_monitor
bind mrpu_host mrpu_host_monitor #(.ADDR_W(ADDR_W), .STARTUP_CYCLES(STARTUP_CYCLES)) mrpu_host_monitor_inst (
  .i_ref_clk, .i_sys_rst, .i_supply_ok, .i_req, .i_we, .o_ready, .o_rvalid,
  .o_mem_cs_n, .o_mem_we_n, .o_mem_oe_n, .o_mem_dq_oe, .o_mem_addr);

/* File: test/mrpu_mem_model.sv */
// Behavioural byte-wide memory answering the host pins
`timescale 1ns/100ps
module mrpu_mem_model (
  input wire logic i_supply_ok,
  input wire logic [16:0] o_mem_addr,
  input wire logic o_mem_cs_n, o_mem_we_n, o_mem_oe_n, o_mem_dq_oe,
  input wire logic [7:0] o_mem_dq,
  output logic [7:0] i_mem_dq
);
  logic [7:0] mem [0:255];
  initial i_mem_dq = 8'h00;
  // Stores only in the strobe overlap, with o_mem_dq_oe high and while i_supply_ok is high
  always @* begin
    if (!o_mem_cs_n && !o_mem_we_n && o_mem_dq_oe && i_supply_ok) mem[o_mem_addr[7:0]] = o_mem_dq;
  end
  // Old data lasts 3 ns, then junk until the worst access delay; junk too once released
  always @(o_mem_addr, o_mem_cs_n, o_mem_oe_n, o_mem_we_n) begin
    i_mem_dq <= #3 ~i_mem_dq;
    if (!o_mem_cs_n && !o_mem_oe_n && o_mem_we_n) i_mem_dq <= #35 mem[o_mem_addr[7:0]];
  end
endmodule // mrpu_mem_model

/* File: test/test_mrpu_host.sv */
// Self-checking bench for the memory host controller
`timescale 1ns/100ps
module test_mrpu_host;
  localparam int SC = 20;
  logic i_ref_clk = 0, i_sys_rst = 1, i_supply_ok = 0, i_req = 0, i_we = 0;
  logic [16:0] i_addr = '0, o_mem_addr;
  logic [7:0] i_wdata = '0, o_rdata, o_mem_dq, i_mem_dq;
  logic o_ready, o_rvalid, o_mem_cs_n, o_mem_we_n, o_mem_oe_n, o_mem_dq_oe;
  int fail_count = 0, comparisons = 0;
  always #25 i_ref_clk = ~i_ref_clk;
  mrpu_host #(.STARTUP_CYCLES(SC)) mrpu_host_inst (.i_ref_clk, .i_sys_rst, .i_supply_ok,
    .i_req, .i_we, .i_addr, .i_wdata, .o_ready, .o_rvalid, .o_rdata, .o_mem_addr, .o_mem_cs_n,
    .o_mem_we_n, .o_mem_oe_n, .i_mem_dq, .o_mem_dq, .o_mem_dq_oe);
  mrpu_mem_model mrpu_mem_model_inst (.i_supply_ok, .o_mem_addr, .o_mem_cs_n, .o_mem_we_n,
    .o_mem_oe_n, .o_mem_dq_oe, .o_mem_dq, .i_mem_dq);
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tick;
    @(posedge i_ref_clk);
    #1;
  endtask
  // Bounded wait for a level; running out ends the run
  task automatic wait_hi(ref logic s, output int n, input int lim);
    n = 0;
    while (s !== 1'b1) begin
      tick;
      n++;
      if (n > lim) begin
        fail_count++;
        stop_test;
      end
    end
  endtask
  task automatic access(input logic we, input logic [16:0] a, input logic [7:0] d);
    int n;
    wait_hi(o_ready, n, 20);
    i_req = 1;
    i_we = we;
    i_addr = a;
    i_wdata = d;
    tick;
    i_req = 0;
    if (!we) begin
      wait_hi(o_rvalid, n, 8);
      check("read data", o_rdata, d);
    end
  endtask
  // Requests during start-up are ignored and ready waits the full count
  task automatic t_startup;
    int n;
    i_supply_ok = 1;
    i_req = 1;
    i_we = 1;
    repeat (5) tick;
    i_req = 0;
    wait_hi(o_ready, n, 200);
    check("startup wait", 8'(n >= SC), 8'h01);
  endtask
  task automatic t_rw;
    access(1, 17'h00000, 8'h00);
    access(1, 17'h00001, 8'hFF);
    access(1, 17'h000FF, 8'hA5);
    access(0, 17'h00000, 8'h00);
    access(0, 17'h00001, 8'hFF);
    access(0, 17'h000FF, 8'hA5);
  endtask
  // Brownout: ready drops, a write is refused, full start-up again
  task automatic t_brownout;
    int n;
    i_supply_ok = 0;
    i_req = 1;
    i_we = 1;
    i_addr = 17'h00001;
    i_wdata = 8'h3C;
    repeat (8) tick;
    check("ready in brownout", 8'(o_ready), 8'h00);
    i_req = 0;
    i_supply_ok = 1;
    wait_hi(o_ready, n, 200);
    check("restart wait", 8'(n >= SC), 8'h01);
    access(0, 17'h00001, 8'hFF);
  endtask
  initial begin
    repeat (4) @(posedge i_ref_clk);
    #1;
    i_sys_rst = 0;
    t_startup;
    t_rw;
    t_brownout;
    stop_test;
  end
endmodule // test_mrpu_host
